// File: design/cbs_top.sv
// Configuration loader, dual boot, security lock, soft error scan and device tag.
// Assumes ref_clk is the undivided on-chip oscillator; link_clk comes from the serial link.
`include "cbs_regs.svh"
`default_nettype none

module cbs_fifo #(
	parameter int W = 8,
	parameter int D = `CBS_FIFO_DEPTH
) (
	input wire logic clk, // Clock
	input wire logic rstn, // Async reset, low
	input wire logic in_vld, // Write valid
	output logic in_rdy, // Not full
	input wire logic [W-1:0] in_data, // Write data
	output logic out_vld, // Not empty
	input wire logic out_rdy, // Read accept
	output logic [W-1:0] out_data // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic wr, rd;
	assign wr = in_vld && in_rdy;
	assign rd = out_vld && out_rdy;
	assign in_rdy = (cnt_r != (AW+1)'(D));
	assign out_vld = (cnt_r != '0);
	assign out_data = mem[rp_r];
	always_ff @(posedge clk) begin
		if (wr) mem[wp_r] <= in_data;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
			if (rd) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule // cbs_fifo

// Notes on behaviour
// [RULE1] Five configuration sources are accepted
// [RULE2] Selected port locked for whole cycle
// [RULE3] Test port activates by instruction anytime
// [RULE4] Optional image CRC check entering user mode
// [RULE5] Config pins are GPIO when unused
// [RULE6] Four test pins optionally GPIO
// [RULE7] Scan path shifts, applies, captures nodes
// [RULE8] Security bits refuse all readback
// [RULE9] Only full erase clears security bits; here reset also clears sec_locked
// [RULE10] OTP rejects erase and reprogram
// [RULE11] Corrupt primary restarts from golden image
// [RULE12] Primary from SPI flash, golden on-chip
// [RULE13] Soft error scan only when enabled
// [RULE14] Fabric input starts soft error scan
// [RULE15] Scan clocked by oscillator divider
// [RULE16] Soft error scan can be switched off
// [RULE17] 64-bit tag, 56 factory, 8 user
// [RULE18] Tag readable by every interface; here only on the tag output port
// [RULE19] Frame check value flags load error
module cbs_top #(
	parameter int FRAME_BYTES = `CBS_FRAME_BYTES,
	parameter int NUM_FRAMES = `CBS_NUM_FRAMES,
	parameter int SED_DIV = `CBS_SED_DIV,
	parameter logic [`CBS_TAG_FACT_BITS-1:0] TAG_FACT = `CBS_TAG_FACT_VAL // Arbitrary
) (
	input wire logic ref_clk, // Oscillator clock
	input wire logic rstn, // Async reset, low
	input wire logic link_clk, // Serial link clock
	input wire logic link_sel_n, // Serial frame select, low
	input wire logic link_mosi, // Serial data, MSB first
	input wire logic cfg_start, // Begin configuration cycle
	input wire cbs_pkg::cbs_src_e cfg_src, // Requested source
	input wire logic dual_boot_en, // Golden fallback enable
	input wire logic crc_chk_en, // Check image CRC at entry
	input wire cbs_pkg::cbs_byte_s nvm_in, // On-chip store bytes
	output logic nvm_rdy, // On-chip store ready
	output logic nvm_restart, // Rewind on-chip store, pulse
	input wire cbs_pkg::cbs_byte_s jtag_in, // Test port bytes
	output logic jtag_rdy, // Test port ready
	input wire cbs_pkg::cbs_byte_s i2c_in, // I2C bytes
	output logic i2c_rdy, // I2C ready
	output cbs_pkg::cbs_stat_s stat, // Load status
	output logic load_err, // Frame check failed, pulse
	output logic link_ovf, // Link byte dropped, sticky
	input wire logic [`CBS_CFG_PINS-1:0] gpio_o, // User pin data
	input wire logic [`CBS_CFG_PINS-1:0] gpio_oe_n, // User pin enables
	output logic [`CBS_CFG_PINS-1:0] cfg_pins_o, // Config pin data
	output logic [`CBS_CFG_PINS-1:0] cfg_pins_oe_n, // Config pin enables
	input wire logic tap_gpio_en, // Test pins as GPIO
	input wire logic [`CBS_TAP_PINS-1:0] tap_pins_i, // Test pin levels
	input wire logic [`CBS_TAP_PINS-1:0] tap_user_o, // User test pin data
	input wire logic [`CBS_TAP_PINS-1:0] tap_user_oe_n, // User test pin enables
	output logic [`CBS_TAP_PINS-1:0] tap_pins_o, // Test pin data
	output logic [`CBS_TAP_PINS-1:0] tap_pins_oe_n, // Test pin enables
	output logic tap_active, // Test port activated
	input wire logic [`CBS_SCAN_W-1:0] node_in, // Captured test nodes
	output logic [`CBS_SCAN_W-1:0] node_out, // Applied test nodes
	input wire logic rb_req, // Readback request
	input wire logic [7:0] rb_addr, // Readback address
	output logic rb_vld, // Readback data, pulse
	output logic [7:0] rb_data, // Readback byte
	output logic rb_refused, // Readback refused, pulse
	input wire logic sec_set, // Set security bits
	input wire logic otp_set, // Enter OTP mode
	input wire logic erase_req, // Full erase
	input wire logic prog_req, // Reprogram store
	output logic prog_ok, // Erase or program taken, pulse
	output logic op_refused, // Erase or program refused, pulse
	output logic sec_locked, // Security bits set
	output logic otp_locked, // OTP mode set
	input wire logic sed_cfg_en, // Scan after configuration
	input wire logic sed_start, // Fabric scan start, pulse
	input wire logic sed_off, // Scan powered off
	input wire logic sed_clr, // Clear scan error
	output logic sed_busy, // Scan running
	output logic sed_err, // Scan mismatch, sticky
	input wire logic tag_wr, // Write user tag byte
	input wire logic [7:0] tag_user, // User tag byte
	output logic [`CBS_TAG_BITS-1:0] tag // Unique device tag
);
	localparam int NW = FRAME_BYTES * NUM_FRAMES;
	localparam int AW = $clog2(NW);
	localparam int FW = $clog2(FRAME_BYTES + 1);
	localparam int NFW = $clog2(NUM_FRAMES + 1);

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `CBS_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// Link domain: shift bytes in; hand each over with a toggle
	logic [2:0] lbit_r;
	logic [7:0] lsh_r, lbyte_r;
	logic ltog_r;
	logic lrst_n;
	assign lrst_n = rstn && !link_sel_n;
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			lbit_r <= '0;
			lsh_r <= '0;
		end else begin
			lbit_r <= lbit_r + 1'b1;
			lsh_r <= {lsh_r[6:0], link_mosi};
		end
	end
	// Byte holds for eight link clocks, far longer than the crossing
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ltog_r <= 1'b0;
			lbyte_r <= '0;
		end else if (!link_sel_n && lbit_r == 3'd7) begin
			ltog_r <= !ltog_r;
			lbyte_r <= {lsh_r[6:0], link_mosi};
		end
	end

	logic [2:0] tsync_r;
	logic lnew;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) tsync_r <= '0;
		else tsync_r <= {tsync_r[1:0], ltog_r};
	end
	assign lnew = tsync_r[2] != tsync_r[1];

	// Source lock and byte mux into the FIFO
	cbs_pkg::cbs_state_e st_r;
	cbs_pkg::cbs_src_e src_r;
	logic f_ivld, f_irdy, f_ovld, f_ordy;
	logic [7:0] f_idata, f_odata;
	always_comb begin
		f_ivld = 1'b0;
		f_idata = '0;
		if (st_r == cbs_pkg::ST_LOAD || st_r == cbs_pkg::ST_TRAIL) begin
			case (src_r) // RULE1 RULE2
				cbs_pkg::SRC_NVM: begin
					f_ivld = nvm_in.vld && nvm_rdy;
					f_idata = nvm_in.data;
				end
				cbs_pkg::SRC_JTAG: begin
					f_ivld = jtag_in.vld && jtag_rdy;
					f_idata = jtag_in.data;
				end
				cbs_pkg::SRC_MSPI, cbs_pkg::SRC_SLAVE_SERIAL_CONFIG_MODE: begin
					f_ivld = lnew;
					f_idata = lbyte_r;
				end
				cbs_pkg::SRC_I2C: begin
					f_ivld = i2c_in.vld && i2c_rdy;
					f_idata = i2c_in.data;
				end
				default: f_ivld = 1'b0;
			endcase
		end
	end

	cbs_fifo #(.W(8), .D(`CBS_FIFO_DEPTH)) u_fifo (
		.clk(ref_clk),
		.rstn(rstn),
		.in_vld(f_ivld),
		.in_rdy(f_irdy),
		.in_data(f_idata),
		.out_vld(f_ovld),
		.out_rdy(f_ordy),
		.out_data(f_odata)
	);
	assign f_ordy = 1'b1;

	// Ready is registered, so it looks one word ahead and drops as the last free entry fills
	logic room;
	assign room = f_irdy && !(f_ivld && u_fifo.cnt_r == 6'(`CBS_FIFO_DEPTH - 1));
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			nvm_rdy <= 1'b0;
			jtag_rdy <= 1'b0;
			i2c_rdy <= 1'b0;
			link_ovf <= 1'b0;
		end else begin
			nvm_rdy <= room && st_r inside {cbs_pkg::ST_LOAD, cbs_pkg::ST_TRAIL}
				&& src_r == cbs_pkg::SRC_NVM;
			jtag_rdy <= room && st_r inside {cbs_pkg::ST_LOAD, cbs_pkg::ST_TRAIL}
				&& src_r == cbs_pkg::SRC_JTAG;
			i2c_rdy <= room && st_r inside {cbs_pkg::ST_LOAD, cbs_pkg::ST_TRAIL}
				&& src_r == cbs_pkg::SRC_I2C;
			if (lnew && !f_irdy) link_ovf <= 1'b1;
		end
	end

	// Loader
	logic [7:0] cmem [NW];
	logic [AW-1:0] wa_r;
	logic [FW-1:0] fb_r;
	logic [NFW-1:0] fn_r;
	logic [7:0] fcrc_r, gcrc_r;
	logic take, frame_bad;
	assign take = f_ovld && f_ordy;
	assign frame_bad = take && st_r == cbs_pkg::ST_LOAD
		&& fb_r == FW'(FRAME_BYTES) && f_odata != fcrc_r;
	always_ff @(posedge ref_clk) begin
		if (take && st_r == cbs_pkg::ST_LOAD && fb_r != FW'(FRAME_BYTES)) cmem[wa_r] <= f_odata;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= cbs_pkg::ST_IDLE;
			src_r <= cbs_pkg::SRC_NVM;
			wa_r <= '0;
			fb_r <= '0;
			fn_r <= '0;
			fcrc_r <= `CBS_CRC_INIT;
			gcrc_r <= `CBS_CRC_INIT;
			stat <= '0;
			load_err <= 1'b0;
			nvm_restart <= 1'b0;
		end else begin
			load_err <= 1'b0;
			nvm_restart <= 1'b0;
			case (st_r)
				cbs_pkg::ST_IDLE, cbs_pkg::ST_USER, cbs_pkg::ST_FAIL: begin
					if (cfg_start && (cfg_src != cbs_pkg::SRC_JTAG || tap_active)) begin
						st_r <= cbs_pkg::ST_LOAD;
						src_r <= cfg_src; // RULE2
						nvm_restart <= (cfg_src == cbs_pkg::SRC_NVM);
						stat <= '0;
						stat.busy <= 1'b1;
						wa_r <= '0;
						fb_r <= '0;
						fn_r <= '0;
						fcrc_r <= `CBS_CRC_INIT;
						gcrc_r <= `CBS_CRC_INIT;
					end
				end
				cbs_pkg::ST_LOAD: if (take) begin
					if (fb_r != FW'(FRAME_BYTES)) begin
						fb_r <= fb_r + 1'b1;
						wa_r <= wa_r + 1'b1;
						fcrc_r <= crc8(fcrc_r, f_odata);
						gcrc_r <= crc8(gcrc_r, f_odata);
					end else if (frame_bad) begin
						load_err <= 1'b1; // RULE19
						if (dual_boot_en && src_r == cbs_pkg::SRC_MSPI) begin
							src_r <= cbs_pkg::SRC_NVM; // RULE11 RULE12
							nvm_restart <= 1'b1;
							stat.golden <= 1'b1;
							wa_r <= '0;
							fb_r <= '0;
							fn_r <= '0;
							fcrc_r <= `CBS_CRC_INIT;
							gcrc_r <= `CBS_CRC_INIT;
						end else begin
							st_r <= cbs_pkg::ST_FAIL;
							stat.busy <= 1'b0;
							stat.fail <= 1'b1;
						end
					end else begin
						fb_r <= '0;
						fcrc_r <= `CBS_CRC_INIT;
						fn_r <= fn_r + 1'b1;
						if (fn_r == NFW'(NUM_FRAMES - 1)) st_r <= cbs_pkg::ST_TRAIL;
					end
				end
				cbs_pkg::ST_TRAIL: if (take) begin
					stat.busy <= 1'b0;
					if (crc_chk_en && f_odata != gcrc_r) begin // RULE4
						st_r <= cbs_pkg::ST_FAIL;
						stat.fail <= 1'b1;
					end else begin
						st_r <= cbs_pkg::ST_USER;
						stat.done <= 1'b1;
						stat.crc_ok <= crc_chk_en;
					end
				end
				default: st_r <= cbs_pkg::ST_IDLE;
			endcase
		end
	end

	// Dual-use configuration pins
	logic pins_cfg;
	assign pins_cfg = stat.busy && src_r != cbs_pkg::SRC_NVM && src_r != cbs_pkg::SRC_JTAG;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_pins_o <= '0;
			cfg_pins_oe_n <= '1;
		end else begin
			cfg_pins_o <= gpio_o;
			cfg_pins_oe_n <= pins_cfg ? '1 : gpio_oe_n; // RULE5
		end
	end

	// Test port: pins synchronised, clock edge found on the second stage
	logic [`CBS_TAP_PINS-1:0] tp1_r, tp2_r;
	logic tck_d_r, tck_rise;
	logic [`CBS_SCAN_W-1:0] sr_r;
	logic tdo_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tp1_r <= '0;
			tp2_r <= '0;
			tck_d_r <= 1'b0;
		end else begin
			tp1_r <= tap_pins_i;
			tp2_r <= tp1_r;
			tck_d_r <= tp2_r[`CBS_TCK_BIT];
		end
	end
	assign tck_rise = tp2_r[`CBS_TCK_BIT] && !tck_d_r && !tap_gpio_en;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sr_r <= '0;
			tdo_r <= 1'b0;
			node_out <= '0;
			tap_active <= 1'b0;
		end else if (tck_rise) begin
			if (!tp2_r[`CBS_TMS_BIT]) begin
				sr_r <= {tp2_r[`CBS_TDI_BIT], sr_r[`CBS_SCAN_W-1:1]}; // RULE7
				tdo_r <= sr_r[0];
			end else begin
				if (sr_r[`CBS_SCAN_W-1 -: 8] == `CBS_TAP_ACT_CODE) tap_active <= 1'b1; // RULE3
				if (tap_active) node_out <= sr_r; // RULE7
				sr_r <= node_in;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tap_pins_o <= '0;
			tap_pins_oe_n <= '1;
		end else if (tap_gpio_en) begin
			tap_pins_o <= tap_user_o; // RULE6
			tap_pins_oe_n <= tap_user_oe_n;
		end else begin
			tap_pins_o <= '0;
			tap_pins_o[`CBS_TDO_BIT] <= tdo_r;
			tap_pins_oe_n <= '1;
			tap_pins_oe_n[`CBS_TDO_BIT] <= 1'b0;
		end
	end

	// Security, OTP, readback
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sec_locked <= 1'b0;
			otp_locked <= 1'b0;
			prog_ok <= 1'b0;
			op_refused <= 1'b0;
			rb_vld <= 1'b0;
			rb_refused <= 1'b0;
			rb_data <= '0;
		end else begin
			prog_ok <= (erase_req || prog_req) && !otp_locked;
			op_refused <= (erase_req || prog_req) && otp_locked; // RULE10
			if (sec_set) sec_locked <= 1'b1;
			else if (erase_req && !otp_locked) sec_locked <= 1'b0; // RULE9
			if (otp_set) otp_locked <= 1'b1;
			rb_vld <= rb_req && !sec_locked;
			rb_refused <= rb_req && sec_locked; // RULE8
			rb_data <= (rb_req && !sec_locked) ? cmem[rb_addr[AW-1:0]] : '0;
		end
	end

	// Soft error scan on a divided tick of the oscillator
	logic [7:0] div_r;
	logic tick;
	logic [AW-1:0] sa_r;
	logic [7:0] scrc_r;
	assign tick = (div_r == 8'(SED_DIV - 1));
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) div_r <= '0;
		else if (sed_off || !sed_busy) div_r <= '0; // RULE16
		else div_r <= tick ? '0 : div_r + 1'b1; // RULE15
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sed_busy <= 1'b0;
			sed_err <= 1'b0;
			sa_r <= '0;
			scrc_r <= `CBS_CRC_INIT;
		end else begin
			// The trailer edge counts as user mode, else the post-load scan could never start
			if (sed_off || !(st_r == cbs_pkg::ST_USER || (st_r == cbs_pkg::ST_TRAIL && take)))
				sed_busy <= 1'b0;
			else if (!sed_busy && (sed_start
				|| (sed_cfg_en && take && st_r == cbs_pkg::ST_TRAIL))) begin
				sed_busy <= 1'b1; // RULE13 RULE14
				sa_r <= '0;
				scrc_r <= `CBS_CRC_INIT;
			end else if (sed_busy && tick) begin
				scrc_r <= crc8(scrc_r, cmem[sa_r]);
				sa_r <= sa_r + 1'b1;
				if (sa_r == AW'(NW - 1)) sed_busy <= 1'b0;
			end
			if (sed_busy && tick && sa_r == AW'(NW - 1) && crc8(scrc_r, cmem[sa_r]) != gcrc_r)
				sed_err <= 1'b1;
			else if (sed_clr) sed_err <= 1'b0;
		end
	end

	// Unique device tag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) tag <= {TAG_FACT, 8'h00};
		else if (tag_wr && !otp_locked) tag <= {TAG_FACT, tag_user}; // RULE17
		else tag <= {TAG_FACT, tag[7:0]}; // RULE18
	end
endmodule // cbs_top
`default_nettype wire

// File: include/cbs_pkg.sv
// Types shared by the configuration block and its bench.
// Assumes cbs_regs.svh is on the include path.
`default_nettype none
package cbs_pkg;
	typedef enum logic [2:0] {SRC_NVM, SRC_JTAG, SRC_MSPI, SRC_SLAVE_SERIAL_CONFIG_MODE, SRC_I2C} cbs_src_e;
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_TRAIL, ST_USER, ST_FAIL} cbs_state_e;
	typedef struct packed {
		logic vld;
		logic [7:0] data;
	} cbs_byte_s;
	typedef struct packed {
		logic busy;
		logic done;
		logic fail;
		logic golden;
		logic crc_ok;
	} cbs_stat_s;
endpackage
`default_nettype wire

// File: include/cbs_regs.svh
// Constants for the configuration, boot and security block.
// Assumes inclusion by the design file, the checker and the bench.
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH
`define CBS_CFG_PINS 10
`define CBS_TAP_PINS 4
`define CBS_FRAME_BYTES 16
`define CBS_NUM_FRAMES 8
`define CBS_FIFO_DEPTH 32
`define CBS_SCAN_W 16
`define CBS_TAP_ACT_CODE 8'hA5
`define CBS_CRC_POLY 8'h07
`define CBS_CRC_INIT 8'hFF
`define CBS_TAG_BITS 64
`define CBS_TAG_FACT_BITS 56
`define CBS_TAG_FACT_VAL 56'h00_1234_5678_9ABC
`define CBS_SED_DIV 8
`define CBS_TDI_BIT 0
`define CBS_TDO_BIT 1
`define CBS_TMS_BIT 2
`define CBS_TCK_BIT 3
`endif

// File: tb/cbs_checker.sv
// Concurrent checks on the configuration block, bound to cbs_top.
// Assumes every watched port belongs to the ref_clk domain.
`include "cbs_regs.svh"
`default_nettype none
module cbs_checker #(
	parameter logic [`CBS_TAG_FACT_BITS-1:0] TAG_FACT = '0
) (
	input wire logic ref_clk, // Clock
	input wire logic rstn, // Reset, low
	input wire logic cfg_start, // Start
	input wire cbs_pkg::cbs_src_e cfg_src, // Source
	input wire logic dual_boot_en, // Fallback on
	input wire logic crc_chk_en, // Image CRC on
	input wire logic nvm_rdy, // Store ready
	input wire logic nvm_restart, // Store rewind
	input wire logic jtag_rdy, // Test ready
	input wire logic i2c_rdy, // I2C ready
	input wire cbs_pkg::cbs_stat_s stat, // Status
	input wire logic load_err, // Frame error
	input wire logic rb_req, // Readback
	input wire logic rb_vld, // Readback data
	input wire logic rb_refused, // Readback refused
	input wire logic sec_set, // Lock
	input wire logic sec_locked, // Locked
	input wire logic otp_locked, // OTP
	input wire logic erase_req, // Erase
	input wire logic prog_req, // Program
	input wire logic prog_ok, // Taken
	input wire logic op_refused, // Refused
	input wire logic sed_cfg_en, // Scan after load
	input wire logic sed_start, // Scan start
	input wire logic sed_off, // Scan off
	input wire logic sed_busy, // Scanning
	input wire logic [`CBS_TAG_BITS-1:0] tag // Tag
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_nvm_go;
		cfg_start && !stat.busy && cfg_src == cbs_pkg::SRC_NVM;
	endsequence
	sequence s_nvm_up;
		##1 (stat.busy && nvm_restart) ##[1:2] nvm_rdy;
	endsequence
	AST_NVM_START: assert property (s_nvm_go |-> s_nvm_up)
		else $error("store source did not come up");
	AST_ONE_PORT: assert property ($onehot0({nvm_rdy, jtag_rdy, i2c_rdy}))
		else $error("two sources ready at once");
	AST_DONE_CRC: assert property ($rose(stat.done) |-> stat.crc_ok == crc_chk_en && !stat.busy)
		else $error("crc flag wrong at done");
	AST_GOLDEN: assert property (load_err && dual_boot_en && cfg_src == cbs_pkg::SRC_MSPI
		&& !$past(stat.golden) |-> ##[0:3] nvm_restart ##[0:3] stat.golden)
		else $error("no golden fallback");
	AST_RB_OK: assert property (rb_req && !sec_locked |=> rb_vld && !rb_refused)
		else $error("open readback not served");
	AST_RB_REFUSE: assert property (rb_req && sec_locked |=> rb_refused && !rb_vld)
		else $error("locked readback served");
	AST_SEC_HOLD: assert property (sec_locked && (!erase_req || otp_locked) |=> sec_locked)
		else $error("lock lost");
	AST_ERASE: assert property (erase_req && !otp_locked && !sec_set |=> prog_ok && !sec_locked)
		else $error("erase did not clear lock");
	AST_OTP: assert property (otp_locked && (erase_req || prog_req) |=> op_refused && !prog_ok)
		else $error("OTP let an operation through");
	AST_SED_CAUSE: assert property ($rose(sed_busy) |-> $past(sed_start) || $past(sed_start, 2)
		|| sed_cfg_en)
		else $error("scan started without cause");
	AST_SED_OFF: assert property (sed_off ##1 sed_off |-> !sed_busy)
		else $error("scan runs while off");
	AST_TAG: assert property (tag[63:8] == TAG_FACT)
		else $error("factory tag bits changed");
endmodule // cbs_checker
bind cbs_top cbs_checker #(.TAG_FACT(TAG_FACT)) chk (.*);
`default_nettype wire

// File: tb/cbs_link_model.sv
// Boot flash partner: streams image bytes over the serial link.
// Assumes the bench calls send; the clock stands still low between frames.
`default_nettype none
module cbs_link_model (
	output logic link_clk, // Link clock
	output logic link_sel_n, // Frame select, low
	output logic link_mosi // Data, MSB first
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk = 1'h0;
		link_sel_n = 1'h1;
		link_mosi = 1'h1;
	end
	task automatic send(input logic [7:0] q[$]);
		#5.7;
		link_sel_n = 1'h0;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				link_mosi = q[i][b];
				#16 link_clk = 1'h1;
				#16 link_clk = 1'h0;
			end
		end
		#16 link_sel_n = 1'h1;
		// Released line shows the opposite level, never a stale bit
		link_mosi = ~link_mosi;
	endtask
endmodule // cbs_link_model
`default_nettype wire

// File: tb/cbs_top_tb.sv
// Bench for cbs_top: store and link loads, scan, pins, locks and tag.
// Assumes cbs_link_model as the boot flash on the link.
`include "cbs_regs.svh"
`default_nettype none
module cbs_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [55:0] TF = 56'h11_2233_4455_6677; // Arbitrary
	localparam int FB = 4;
	localparam int NF = 2;
	int fails = 0;
	int compares = 0;
	logic ref_clk = 1'h0, rstn = 1'h0, link_clk, link_sel_n, link_mosi, cfg_start = 1'h0;
	logic dual_boot_en = 1'h0, crc_chk_en = 1'h1, nvm_rdy, nvm_restart, jtag_rdy, i2c_rdy;
	logic load_err, link_ovf, tap_gpio_en = 1'h0, tap_active, rb_req = 1'h0, rb_vld;
	logic sec_set = 1'h0, otp_set = 1'h0, erase_req = 1'h0, prog_req = 1'h0, prog_ok;
	logic sec_locked, otp_locked, sed_cfg_en = 1'h1, sed_start = 1'h0, sed_off = 1'h0;
	logic sed_clr = 1'h0, sed_busy, sed_err, tag_wr = 1'h0, rb_refused, op_refused;
	logic [5:0] seen = 6'h00;
	logic clr_seen = 1'h0;
	logic [7:0] rb_addr = 8'h03, rb_data, tag_user = 8'h5C;
	logic [9:0] gpio_o = 10'h000, gpio_oe_n = 10'h3FF, cfg_pins_o, cfg_pins_oe_n;
	logic [3:0] tap_pins_i = 4'h0, tap_user_o = 4'h0, tap_user_oe_n = 4'hF;
	logic [3:0] tap_pins_o, tap_pins_oe_n;
	logic [15:0] node_in = 16'h0000, node_out;
	logic [63:0] tag;
	cbs_pkg::cbs_src_e cfg_src = cbs_pkg::SRC_NVM;
	cbs_pkg::cbs_byte_s nvm_in = '0, jtag_in = '0, i2c_in = '0;
	cbs_pkg::cbs_stat_s stat;
	cbs_link_model lnk (.link_clk(link_clk), .link_sel_n(link_sel_n), .link_mosi(link_mosi));
	cbs_top #(.FRAME_BYTES(FB), .NUM_FRAMES(NF), .SED_DIV(2), .TAG_FACT(TF)) dut (.*);
	initial forever #2 ref_clk = ~ref_clk;
	// Pulses are latched so checks do not hang on an exact latency
	always @(posedge ref_clk) begin
		seen <= (clr_seen ? 6'h00 : seen) | {load_err, nvm_restart, rb_vld, rb_refused, prog_ok,
			op_refused};
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		clr_seen = 1'h1;
		s = 1'h1;
		tick(1);
		clr_seen = 1'h0;
		s = 1'h0;
		tick(3);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
		return r;
	endfunction
	// Frames of data plus check byte, then a trailer over all data; flip spoils frame 0
	task automatic build(output logic [7:0] q[$], input logic [7:0] flip);
		logic [7:0] c, t, d;
		t = 8'hFF;
		q = {};
		for (int f = 0; f < NF; f++) begin
			c = 8'hFF;
			for (int i = 0; i < FB; i++) begin
				d = {f[3:0], i[3:0]} ^ 8'hA3;
				c = crc8(c, d);
				t = crc8(t, d);
				q.push_back(d);
			end
			q.push_back(f == 0 ? c ^ flip : c);
		end
		q.push_back(t);
	endtask
	task automatic feed(input logic [7:0] q[$]);
		int k;
		foreach (q[i]) begin
			nvm_in = {1'h1, q[i]};
			for (k = 0; k < 100 && nvm_rdy !== 1'h1; k++) tick(1);
			tick(1);
		end
		nvm_in = '0;
		for (k = 0; k < 200 && stat.done !== 1'h1; k++) tick(1);
	endtask
	task automatic t_load();
		logic [7:0] q[$];
		build(q, 8'h00);
		cfg_src = cbs_pkg::SRC_NVM;
		pulse(cfg_start);
		check(seen[4], 1'h1);
		feed(q);
		check(stat, 5'h09);
		tick(2);
		check(sed_busy, 1'h1);
		for (int k = 0; k < 100 && sed_busy !== 1'h0; k++) tick(1);
		check(sed_err, 1'h0);
		pulse(sed_start);
		check(sed_busy, 1'h1);
		sed_off = 1'h1;
		tick(3);
		check(sed_busy, 1'h0);
		pulse(sed_start);
		check(sed_busy, 1'h0);
		sed_off = 1'h0;
		pulse(sed_clr);
		$display("test load done");
	endtask
	task automatic t_pins();
		gpio_o = 10'h2A5;
		gpio_oe_n = 10'h0F0;
		tap_gpio_en = 1'h1;
		tap_user_o = 4'hA;
		tap_user_oe_n = 4'h3;
		tick(4);
		check({cfg_pins_o, cfg_pins_oe_n}, {10'h2A5, 10'h0F0});
		check({tap_pins_o, tap_pins_oe_n}, {4'hA, 4'h3});
		$display("test pins done");
	endtask
	task automatic t_dual();
		logic [7:0] q[$];
		build(q, 8'h5A);
		dual_boot_en = 1'h1;
		sed_cfg_en = 1'h0;
		cfg_src = cbs_pkg::SRC_MSPI;
		pulse(cfg_start);
		check(nvm_rdy, 1'h0);
		check(cfg_pins_oe_n, 10'h3FF);
		lnk.send(q[0:FB]);
		for (int k = 0; k < 100 && seen[4] !== 1'h1; k++) tick(1);
		check(seen[5:4], 2'h3);
		build(q, 8'h00);
		feed(q);
		check({stat, link_ovf}, 6'h16);
		$display("test dual done");
	endtask
	task automatic t_lock();
		check(tag, {TF, 8'h00});
		pulse(tag_wr);
		check(tag, {TF, 8'h5C});
		rb_req = 1'h1;
		tick(1);
		rb_req = 1'h0;
		check({rb_vld, rb_refused, rb_data}, 10'h2A0);
		tick(3);
		pulse(sec_set);
		pulse(rb_req);
		check({seen[3:2], sec_locked}, 3'h3);
		pulse(erase_req);
		check({seen[1:0], sec_locked}, 3'h4);
		pulse(sec_set);
		pulse(otp_set);
		pulse(prog_req);
		check({seen[1:0], otp_locked}, 3'h3);
		pulse(erase_req);
		check({seen[1:0], sec_locked}, 3'h3);
		tag_user = 8'hA7;
		pulse(tag_wr);
		check(tag, {TF, 8'h5C});
		$display("test lock done");
	endtask
	// One test clock: levels settle through the pin synchronisers before the rise
	task automatic tap_clk(input logic tms, input logic tdi, output logic tdo);
		tap_pins_i = {1'h0, tms, 1'h0, tdi};
		tick(3);
		tap_pins_i[3] = 1'h1;
		tick(4);
		tdo = tap_pins_o[1];
	endtask
	task automatic t_tap();
		logic [15:0] v, w, cap;
		logic d;
		v = 16'hA5C3;
		w = 16'h3C96;
		tap_gpio_en = 1'h0;
		node_in = 16'h6E19;
		tick(3);
		check(tap_pins_oe_n, 4'hD);
		for (int i = 0; i < 16; i++) tap_clk(1'h0, v[i], d);
		tap_clk(1'h1, 1'h0, d);
		check({tap_active, node_out}, {1'h1, 16'h0000});
		for (int i = 0; i < 16; i++) tap_clk(1'h0, w[i], cap[i]);
		tap_clk(1'h1, 1'h0, d);
		check({node_out, cap}, {16'h3C96, 16'h6E19});
		cfg_src = cbs_pkg::SRC_JTAG;
		pulse(cfg_start);
		check({nvm_rdy, jtag_rdy, i2c_rdy}, 3'h2);
		$display("test tap done");
	endtask
	task automatic finish_test();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		finish_test();
	end
	initial begin
		tick(20);
		rstn = 1'h1;
		tick(3);
		t_load();
		t_pins();
		t_dual();
		t_lock();
		t_tap();
		finish_test();
	end
endmodule // cbs_top_tb
`default_nettype wire
